// ==== rxb_bank.sv ====
// Purpose: Extended register bank: extended RAM, control registers, address stack.
// Assumes: Host bus pins are synchronous to CLK; chip select, read and write strobes active low, latch strobe active high.
// Notes: Registers only answer while bank one is selected by the host.
module rxb_bank
    import rxb_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESETN,
    // Multiplexed host bus.
    input wire logic [7:0] AD_IN,
    output logic [7:0] AD_OUT,
    output logic AD_OE_N,
    input wire logic ALE,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic BANK_SELECT,
    // Power and wake pins.
    input wire logic MAIN_POWER,
    input wire logic AUX_BATTERY_IN,
    input wire logic ALARM_MATCH,
    input wire logic UPDATE_SOON,
    input wire logic UPDATE_DONE,
    input wire logic OTHER_IRQ,
    input wire logic WAKE_KEY_IN,
    input wire logic RAM_WIPE_IN,
    output logic POWER_ON_OUT_OE_N,
    output logic INTERRUPT_OUT_OE_N,
    output logic SQUARE_WAVE_OUT,
    output logic CRYSTAL_LOAD_SEL,
    output logic AUX_BATT_ENABLE,
    // User RAM wipe port.
    output logic USER_WIPE_WE,
    output logic [7:0] USER_WIPE_ADDR
);
    logic [1:0] rst_sync_reg; // Reset release synchroniser.
    logic rst_n; // Synchronised reset.
    logic [7:0] addr_reg; // Latched bus address.
    logic [6:0] ram_addr_reg; // Extended RAM address.
    logic [7:0] ram_mem [RAM_DEPTH]; // Extended RAM storage.
    logic [7:0] stack_reg [4]; // Recovery stack, 0 is newest.
    logic [7:0] feat_reg; // Feature enable register.
    logic [1:0] spare_reg; // Spare storage bits 5:4.
    logic pwr_off_reg; // Power-off request.
    logic wipe_flag_reg; // Wipe complete flag.
    logic alarm_flag_reg; // Alarm wake flag.
    logic key_flag_reg; // Key wake flag.
    logic upd_pend_reg; // Update pending.
    logic [7:0] rd_data_reg; // Read data driven on the bus.
    logic rd_oe_reg; // Read drive enable.
    logic wr_last_reg; // Previous write strobe level.
    logic ale_fall; // Address latch edge.
    logic ale_last_reg; // Previous latch strobe level, idles low.
    logic wipe_fall; // Wipe pin falling.
    logic key_fall; // Key pin falling.
    logic power_last_reg; // Previous main power level.
    logic fail_released_reg; // Pin released by power fail.
    logic wiping_reg; // Wipe sweep running.
    logic [7:0] wipe_addr_reg; // Wipe sweep position.
    logic [15:0] lock_cnt_reg; // Access lockout counter.
    logic [15:0] sq_cnt_reg; // Square wave divider.
    logic sq_reg; // Square wave phase.
    logic sq_out_reg; // Registered square output.
    logic pwr_oe_n_reg; // Registered power pin enable.
    logic irq_oe_n_reg; // Registered interrupt enable.
    logic xtal_reg; // Registered crystal select.
    logic aux_en_reg; // Registered battery enable.
    logic wr_fire; // Write strobe rising edge completes a write.
    logic access_ok; // Selected, bank one, not locked out.
    logic irq_any; // Combined interrupt request.
    logic wake_clear; // Enabled wake flag pending.

    // Release reset through two flip-flops.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // The latch strobe idles low, so its history resets low to avoid a false fall.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ale_last_reg <= 1'b0;
        end else begin
            ale_last_reg <= ALE;
        end
    end
    assign ale_fall = ale_last_reg & ~ALE;

    // Edge detectors for the wipe and key inputs, which idle high.
    rxb_edge u_wipe (.clk(CLK), .rst_n(rst_n), .level_in(RAM_WIPE_IN), .fall_out(wipe_fall));
    rxb_edge u_key (.clk(CLK), .rst_n(rst_n), .level_in(WAKE_KEY_IN), .fall_out(key_fall));

    // Host accesses need chip select and bank one, and no wipe lockout.
    assign access_ok = !CS_N && BANK_SELECT && (lock_cnt_reg == 16'h0000);
    assign wr_fire = access_ok && WR_N && !wr_last_reg;
    assign wake_clear = (alarm_flag_reg && feat_reg[BIT_ALARM_EN])
                      || (key_flag_reg && feat_reg[BIT_KEY_EN]);

    // Track the write strobe so a write takes effect once on its release.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_last_reg <= 1'b1;
        end else begin
            wr_last_reg <= WR_N;
        end
    end

    // Latch the bus address and push it onto the recovery stack.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                stack_reg[i] <= 8'h00;
            end
        end else if (ale_fall) begin
            addr_reg <= AD_IN;
            stack_reg[0] <= AD_IN;
            for (int i = 1; i < 4; i++) begin
                stack_reg[i] <= stack_reg[i - 1];
            end
        end
    end

    // The extended RAM address register.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ram_addr_reg <= 7'h00;
        end else if (wr_fire && addr_reg == OFF_RAM_ADDR) begin
            ram_addr_reg <= AD_IN[6:0];
        end
    end

    // Extended RAM writes through the data port; the address is untouched.
    always_ff @(posedge CLK) begin
        if (wr_fire && addr_reg == OFF_RAM_DATA) begin
            ram_mem[ram_addr_reg] <= AD_IN;
        end
    end

    // Feature enable register; a rise of main power sets the 32 kHz enable.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            feat_reg <= RST_FEATURE_EN;
        end else begin
            if (wr_fire && addr_reg == OFF_FEATURE_EN) begin
                feat_reg <= AD_IN;
            end
            if (MAIN_POWER && !power_last_reg) begin
                feat_reg[BIT_CLK32_EN] <= 1'b1;
            end
        end
    end

    // Status/control writable fields: spare bits and power-off request.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            spare_reg <= RST_SPARE[1:0];
            pwr_off_reg <= 1'b0;
        end else begin
            if (wr_fire && addr_reg == OFF_STATUS_CTRL) begin
                spare_reg <= AD_IN[5:4];
                pwr_off_reg <= AD_IN[BIT_PWR_OFF];
            end
            if (wake_clear) begin
                pwr_off_reg <= 1'b0;
            end
        end
    end

    // Sticky flags: hardware set wins over a host clear in the same cycle.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wipe_flag_reg <= 1'b0;
            alarm_flag_reg <= 1'b0;
            key_flag_reg <= 1'b0;
        end else begin
            if (wr_fire && addr_reg == OFF_STATUS_CTRL) begin
                wipe_flag_reg <= AD_IN[BIT_WIPE_FLAG];
                alarm_flag_reg <= AD_IN[BIT_ALARM_FLAG];
                key_flag_reg <= AD_IN[BIT_KEY_FLAG];
            end
            if (wiping_reg && wipe_addr_reg == USER_RAM_LAST) begin
                wipe_flag_reg <= 1'b1;
            end
            if (ALARM_MATCH) begin
                alarm_flag_reg <= 1'b1;
            end
            if (key_fall && feat_reg[BIT_KEY_EN]) begin
                key_flag_reg <= 1'b1;
            end
        end
    end

    // Wipe sweep: a fall on the enabled wipe pin clears user RAM to ones.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wiping_reg <= 1'b0;
            wipe_addr_reg <= 8'h00;
            lock_cnt_reg <= 16'h0000;
        end else begin
            if (wipe_fall && feat_reg[BIT_WIPE_EN] && !wiping_reg) begin
                wiping_reg <= 1'b1;
                wipe_addr_reg <= 8'h00;
                lock_cnt_reg <= 16'(WIPE_RECOVER_CYC);
            end else begin
                if (wiping_reg) begin
                    // Sweep ends after the last user byte.
                    wiping_reg <= (wipe_addr_reg != USER_RAM_LAST);
                    wipe_addr_reg <= wipe_addr_reg + 8'h01;
                end
                if (lock_cnt_reg != 16'h0000) begin
                    lock_cnt_reg <= lock_cnt_reg - 16'h0001;
                end
            end
        end
    end

    // Drive the user RAM wipe port from registers.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            USER_WIPE_WE <= 1'b0;
            USER_WIPE_ADDR <= 8'h00;
        end else begin
            USER_WIPE_WE <= wiping_reg;
            USER_WIPE_ADDR <= wipe_addr_reg;
        end
    end

    // Update pending: rises on the early warning, holds to the update end.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            upd_pend_reg <= 1'b0;
        end else begin
            // The warning pulse already arrives the lead time ahead of the update.
            if (UPDATE_DONE) begin
                upd_pend_reg <= 1'b0;
            end else if (UPDATE_SOON) begin
                upd_pend_reg <= 1'b1;
            end
        end
    end

    // Read mux: drive the bus while the read strobe is low.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
            rd_oe_reg <= 1'b0;
        end else begin
            rd_oe_reg <= access_ok && !RD_N;
            unique case (addr_reg)
                OFF_STATUS_CTRL: rd_data_reg <= {AUX_BATTERY_IN, upd_pend_reg, spare_reg,
                    pwr_off_reg, wipe_flag_reg, alarm_flag_reg, key_flag_reg};
                OFF_FEATURE_EN: rd_data_reg <= feat_reg;
                OFF_STACK_LO: rd_data_reg <= stack_reg[2];
                OFF_STACK_HI: rd_data_reg <= stack_reg[1];
                OFF_RAM_ADDR: rd_data_reg <= {1'b0, ram_addr_reg};
                OFF_RAM_DATA: rd_data_reg <= ram_mem[ram_addr_reg];
                default: rd_data_reg <= 8'h00; // Unmapped reads as zero.
            endcase
        end
    end
    assign AD_OUT = rd_data_reg;
    assign AD_OE_N = ~rd_oe_reg;

    // Power-fail handling: the pin lets go on a fall unless held.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            power_last_reg <= 1'b0;
            fail_released_reg <= 1'b0;
        end else begin
            power_last_reg <= MAIN_POWER;
            if (power_last_reg && !MAIN_POWER && !feat_reg[BIT_HOLD_FAIL]) begin
                fail_released_reg <= 1'b1;
            end else if (MAIN_POWER || wake_clear) begin
                fail_released_reg <= 1'b0;
            end
        end
    end

    // Interrupt combination of enabled flags and other sources.
    assign irq_any = (wipe_flag_reg && feat_reg[BIT_WIPE_IRQ])
                   || (alarm_flag_reg && feat_reg[BIT_ALARM_EN])
                   || (key_flag_reg && feat_reg[BIT_KEY_EN])
                   || OTHER_IRQ;

    // Open-drain pins: enable low means driving low.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pwr_oe_n_reg <= 1'b1;
            irq_oe_n_reg <= 1'b1;
        end else begin
            pwr_oe_n_reg <= pwr_off_reg || fail_released_reg;
            irq_oe_n_reg <= !(irq_any && MAIN_POWER);
        end
    end
    assign POWER_ON_OUT_OE_N = pwr_oe_n_reg;
    assign INTERRUPT_OUT_OE_N = irq_oe_n_reg;

    // Square wave divider standing in for the oscillator output.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sq_cnt_reg <= 16'h0000;
            sq_reg <= 1'b0;
            sq_out_reg <= 1'b0;
        end else begin
            if (sq_cnt_reg == 16'(HALF_32K_CYC - 1)) begin
                sq_cnt_reg <= 16'h0000;
                sq_reg <= ~sq_reg;
            end else begin
                sq_cnt_reg <= sq_cnt_reg + 16'h0001;
            end
            sq_out_reg <= sq_reg && feat_reg[BIT_CLK32_EN];
        end
    end
    assign SQUARE_WAVE_OUT = sq_out_reg;

    // Oscillator and battery controls as registered outputs.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            xtal_reg <= 1'b0;
            aux_en_reg <= 1'b0;
        end else begin
            xtal_reg <= feat_reg[BIT_XTAL_SEL];
            aux_en_reg <= feat_reg[BIT_AUX_EN];
        end
    end
    assign CRYSTAL_LOAD_SEL = xtal_reg;
    assign AUX_BATT_ENABLE = aux_en_reg;
endmodule

// ==== rxb_checker.sv ====
// Purpose: Port-level checks of the extended register bank.
// Assumes: One clock domain; RESETN is the active-low pin reset.
// Notes: Reads are only expected to answer well clear of a wipe.
module rxb_checker
    import rxb_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESETN,
    // Host bus pins.
    input wire logic AD_OE_N,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic BANK_SELECT,
    // Power, interrupt and wipe pins.
    input wire logic MAIN_POWER,
    input wire logic OTHER_IRQ,
    input wire logic INTERRUPT_OUT_OE_N,
    input wire logic USER_WIPE_WE,
    input wire logic [7:0] USER_WIPE_ADDR
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    logic [4:0] quiet_reg; // Cycles since reset or the last wipe step, saturating.
    // Reads may be refused just after reset or a wipe, so count the calm time.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN)
            quiet_reg <= 5'h00;
        else if (USER_WIPE_WE)
            quiet_reg <= 5'h00;
        else if (quiet_reg != 5'h1f)
            quiet_reg <= quiet_reg + 5'h01;
    end
    a_rd_gates_drive: assert property ($past(RD_N) && $past(RD_N, 2) |-> AD_OE_N)
        else $error("bus driven without a read strobe");
    a_cs_gates_drive: assert property ($past(CS_N) && $past(CS_N, 2) |-> AD_OE_N)
        else $error("bus driven without chip select");
    a_bank_gates_drive: assert property (!$past(BANK_SELECT) && !$past(BANK_SELECT, 2)
        |-> AD_OE_N)
        else $error("bus driven with bank one not selected");
    a_read_answer: assert property (!RD_N && $past(RD_N) && !CS_N && BANK_SELECT
        && quiet_reg >= 5'h10 |=> !AD_OE_N)
        else $error("read not answered one cycle after the strobe");
    a_wipe_lockout: assert property ($past(USER_WIPE_WE) && $past(USER_WIPE_WE, 2)
        |-> AD_OE_N)
        else $error("bus driven during a wipe");
    a_wipe_first_byte: assert property ($rose(USER_WIPE_WE) |-> USER_WIPE_ADDR == 8'h00)
        else $error("wipe does not start at byte zero");
    a_wipe_step_one: assert property (USER_WIPE_WE && $past(USER_WIPE_WE)
        |-> USER_WIPE_ADDR == $past(USER_WIPE_ADDR) + 8'h01)
        else $error("wipe address skipped");
    a_wipe_last_byte: assert property ($fell(USER_WIPE_WE)
        |-> $past(USER_WIPE_ADDR) == USER_RAM_LAST)
        else $error("wipe did not end at the last user byte");
    a_irq_no_power: assert property (!MAIN_POWER [*3] |=> INTERRUPT_OUT_OE_N)
        else $error("interrupt driven without main power");
    a_irq_other_src: assert property ((MAIN_POWER && OTHER_IRQ) [*3] |=> !INTERRUPT_OUT_OE_N)
        else $error("other interrupt source not passed on");
    c_read: cover property (!RD_N ##1 !AD_OE_N);
    c_wipe_done: cover property ($fell(USER_WIPE_WE));
    c_irq: cover property ($fell(INTERRUPT_OUT_OE_N));
endmodule

// ==== rxb_edge.sv ====
// Purpose: Falling-edge detector on a registered history of an input level.
// Assumes: Input is synchronous to the clock.
// Notes: Used for the wipe and key inputs, which idle high.
module rxb_edge (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Level in and one-cycle pulse out.
    input wire logic level_in,
    output logic fall_out
);
    logic last_reg; // Previous sample, idles high.

    // Remember the last sample; a fall is high then low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_reg <= 1'b1;
        end else begin
            last_reg <= level_in;
        end
    end

    // The pulse is combinational on the registered history.
    assign fall_out = last_reg & ~level_in;
endmodule

// ==== rxb_host.sv ====
// Purpose: Behavioural host processor on the multiplexed address/data bus.
// Assumes: The bank samples bus pins on the rising clock edge.
// Notes: Pins change at the falling edge; released data shows the inverse value.
module rxb_host_model
    import rxb_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Read answer from the bank.
    input wire logic [7:0] ad_out,
    input wire logic ad_oe_n,
    // Bus pins driven by the host.
    output logic [7:0] ad_in,
    output logic ale,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic bank_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus with bank one selected before any access.
    initial begin
        ad_in = 8'h00;
        ale = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        bank_sel = 1'b1;
    end
    // Present an address and drop the latch strobe; it is taken at the next rising edge.
    task automatic latch(input logic [7:0] a);
        @(negedge clk);
        ale = 1'b1;
        ad_in = a;
        @(negedge clk);
        ale = 1'b0;
    endtask
    // Write one byte; data is held across the rising edge of the write strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        latch(a);
        @(negedge clk);
        cs_n = 1'b0;
        wr_n = 1'b0;
        ad_in = d;
        @(negedge clk);
        wr_n = 1'b1;
        @(negedge clk);
        cs_n = 1'b1;
        ad_in = ~d;
    endtask
    // Read one byte; ok stays low when the bank never drives the bus.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        latch(a);
        @(negedge clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        ad_in = ~a;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            if (ad_oe_n === 1'b0) begin
                d = ad_out;
                ok = 1'b1;
                break;
            end
        end
        @(negedge clk);
        rd_n = 1'b1;
        cs_n = 1'b1;
    endtask
endmodule

// ==== rxb_pkg.sv ====
// Purpose: Shared constants for the clock's extended register bank.
// Assumes: One 125 MHz clock, byte-wide multiplexed host bus.
// Notes: Offsets are bank-one register addresses on the multiplexed bus.
package rxb_pkg;
    // Register offsets in bank one.
    localparam logic [7:0] OFF_STATUS_CTRL = 8'h4a;
    localparam logic [7:0] OFF_FEATURE_EN = 8'h4b;
    localparam logic [7:0] OFF_STACK_LO = 8'h4e;
    localparam logic [7:0] OFF_STACK_HI = 8'h4f;
    localparam logic [7:0] OFF_RAM_ADDR = 8'h50;
    localparam logic [7:0] OFF_RAM_DATA = 8'h53;
    // Extended RAM geometry.
    localparam int RAM_DEPTH = 128;
    localparam logic [6:0] RAM_LAST = 7'h7f;
    // User RAM size cleared by a wipe.
    localparam int USER_RAM_BYTES = 242;
    localparam logic [7:0] USER_RAM_LAST = 8'hf1;
    // Status/control bit positions.
    localparam int BIT_AUX_OK = 7;
    localparam int BIT_UPD_PEND = 6;
    localparam int BIT_PWR_OFF = 3;
    localparam int BIT_WIPE_FLAG = 2;
    localparam int BIT_ALARM_FLAG = 1;
    localparam int BIT_KEY_FLAG = 0;
    // Feature enable bit positions.
    localparam int BIT_AUX_EN = 7;
    localparam int BIT_CLK32_EN = 6;
    localparam int BIT_XTAL_SEL = 5;
    localparam int BIT_WIPE_EN = 4;
    localparam int BIT_HOLD_FAIL = 3;
    localparam int BIT_WIPE_IRQ = 2;
    localparam int BIT_ALARM_EN = 1;
    localparam int BIT_KEY_EN = 0;
    // Reset values.
    localparam logic [7:0] RST_FEATURE_EN = 8'h40;
    localparam logic [5:0] RST_SPARE = 6'h00;
    // Timing at 125 MHz.
    localparam int CLK_PERIOD_NS = 8;
    localparam int UPD_LEAD_US = 122;
    localparam int UPD_LEAD_CYC = (UPD_LEAD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WIPE_RECOVER_NS = 2000;
    localparam int WIPE_RECOVER_CYC = (WIPE_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Cycles of a 32.768 kHz half period at 125 MHz, approximated.
    localparam int HALF_32K_CYC = 1907;
endpackage

// ==== testbench.sv ====
// Purpose: Self-checking bench for the extended register bank.
// Assumes: Host model drives the bus; this module drives power and wake pins.
// Notes: Inputs change at the falling edge of the clock.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rxb_pkg::*;
    logic clk, rst_n, main_power, aux_in, alarm, upd_soon, upd_done, other_irq;
    logic key_in_n, wipe_in_n, ad_oe_n, ale, cs_n, rd_n, wr_n, bank, ok, s0;
    logic pwr_oe_n, irq_oe_n, square_wave_out, xtal, abe, user_we;
    logic [7:0] ad_in, ad_out, user_addr, rdat;
    int bad_count, n_checks, wipes;
    rxb_bank DUT (.CLK(clk), .RESETN(rst_n), .AD_IN(ad_in), .AD_OUT(ad_out),
        .AD_OE_N(ad_oe_n), .ALE(ale), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
        .BANK_SELECT(bank), .MAIN_POWER(main_power), .AUX_BATTERY_IN(aux_in),
        .ALARM_MATCH(alarm), .UPDATE_SOON(upd_soon), .UPDATE_DONE(upd_done),
        .OTHER_IRQ(other_irq), .WAKE_KEY_IN(key_in_n), .RAM_WIPE_IN(wipe_in_n),
        .POWER_ON_OUT_OE_N(pwr_oe_n), .INTERRUPT_OUT_OE_N(irq_oe_n),
        .SQUARE_WAVE_OUT(square_wave_out), .CRYSTAL_LOAD_SEL(xtal), .AUX_BATT_ENABLE(abe),
        .USER_WIPE_WE(user_we), .USER_WIPE_ADDR(user_addr));
    rxb_host_model host (.clk(clk), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ad_in(ad_in),
        .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .bank_sel(bank));
    // Free-running 125 MHz clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Count wipe steps seen on the user RAM port.
    always @(posedge clk) begin
        if (user_we === 1'b1)
            wipes <= wipes + 1;
    end
    // Compare tasks print a line and count each mismatch.
    task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(string what, logic exp, logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask
    // Read a register and expect it to be driven with a value.
    task automatic rdchk(string what, logic [7:0] a, logic [7:0] exp);
        host.rd(a, rdat, ok);
        chk1(what, 1'b1, ok);
        chk8(what, exp, rdat);
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Cut a hang short.
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("Error watchdog expected finish seen hang");
        end_of_test();
    end
    // Main sequence of tests.
    initial begin
        {main_power, aux_in, key_in_n, wipe_in_n} = 4'hf;
        {alarm, upd_soon, upd_done, other_irq, rst_n} = 5'h00;
        bad_count = 0;
        n_checks = 0;
        wipes = 0;
        cyc(8);
        rst_n = 1'b1;
        cyc(4);
        rdchk("feature", OFF_FEATURE_EN, RST_FEATURE_EN);
        rdchk("status", OFF_STATUS_CTRL, 8'h80);
        chk1("power pin", 1'b0, pwr_oe_n);
        aux_in = 1'b0;
        rdchk("aux low", OFF_STATUS_CTRL, 8'h00);
        aux_in = 1'b1;
        $display("test reset finished");
        host.wr(OFF_RAM_ADDR, {1'b0, RAM_LAST});
        host.wr(OFF_RAM_DATA, 8'ha5);
        host.wr(OFF_RAM_ADDR, 8'h00);
        host.wr(OFF_RAM_DATA, 8'h5a);
        host.wr(OFF_RAM_ADDR, {1'b0, RAM_LAST});
        rdchk("ram top", OFF_RAM_DATA, 8'ha5);
        rdchk("ram again", OFF_RAM_DATA, 8'ha5);
        rdchk("ram addr", OFF_RAM_ADDR, {1'b0, RAM_LAST});
        host.wr(OFF_FEATURE_EN, 8'he0);
        rdchk("feature rw", OFF_FEATURE_EN, 8'he0);
        chk1("aux enable", 1'b1, abe);
        chk1("crystal", 1'b1, xtal);
        s0 = square_wave_out;
        for (int i = 0; i < 2 * HALF_32K_CYC + 20 && square_wave_out === s0; i++)
            @(negedge clk);
        chk1("square wave", 1'b1, square_wave_out !== s0);
        $display("test ram and features finished");
        host.wr(OFF_FEATURE_EN, 8'h00);
        cyc(2);
        chk1("crystal off", 1'b0, xtal);
        host.wr(OFF_STATUS_CTRL, 8'h37);
        rdchk("flags set", OFF_STATUS_CTRL, 8'hb7);
        chk1("irq masked", 1'b1, irq_oe_n);
        host.wr(OFF_STATUS_CTRL, 8'h08);
        rdchk("flags clear", OFF_STATUS_CTRL, 8'h88);
        chk1("power off", 1'b1, pwr_oe_n);
        // Key wake first, then alarm wake.
        for (int k = 0; k < 2; k++) begin
            host.wr(OFF_FEATURE_EN, 8'(8'h01 << k));
            host.wr(OFF_STATUS_CTRL, 8'h08);
            key_in_n = (k != 0);
            alarm = (k == 1);
            cyc(2);
            key_in_n = 1'b1;
            alarm = 1'b0;
            cyc(3);
            rdchk("wake flag", OFF_STATUS_CTRL, 8'(8'h80 | (8'h01 << k)));
            chk1("wake power", 1'b0, pwr_oe_n);
            chk1("wake irq", 1'b0, irq_oe_n);
            host.wr(OFF_STATUS_CTRL, 8'h00);
            cyc(2);
            chk1("irq released", 1'b1, irq_oe_n);
        end
        // Power fail without and then with the hold bit.
        for (int h = 0; h < 2; h++) begin
            host.wr(OFF_FEATURE_EN, 8'(h << 3));
            other_irq = 1'b1;
            cyc(4);
            chk1("other irq", 1'b0, irq_oe_n);
            main_power = 1'b0;
            cyc(4);
            chk1("fail power", h == 0, pwr_oe_n);
            main_power = 1'b1;
            other_irq = 1'b0;
            cyc(4);
        end
        upd_soon = 1'b1;
        cyc(1);
        upd_soon = 1'b0;
        rdchk("update on", OFF_STATUS_CTRL, 8'hc0);
        upd_done = 1'b1;
        cyc(1);
        upd_done = 1'b0;
        rdchk("update off", OFF_STATUS_CTRL, 8'h80);
        $display("test flags finished");
        host.rd(OFF_RAM_ADDR, rdat, ok);
        host.latch(8'h0a);
        rdchk("stack lo", OFF_STACK_LO, OFF_RAM_ADDR);
        rdchk("stack hi", OFF_STACK_HI, OFF_STACK_LO);
        host.bank_sel = 1'b0;
        host.wr(OFF_RAM_DATA, 8'h11);
        host.rd(OFF_STATUS_CTRL, rdat, ok);
        chk1("bank off", 1'b0, ok);
        host.bank_sel = 1'b1;
        rdchk("unmapped", 8'h60, 8'h00);
        rdchk("ram kept", OFF_RAM_DATA, 8'ha5);
        $display("test stack and refusals finished");
        host.wr(OFF_FEATURE_EN, 8'h14);
        wipes = 0;
        wipe_in_n = 1'b0;
        cyc(3);
        host.rd(OFF_STATUS_CTRL, rdat, ok);
        chk1("lockout", 1'b0, ok);
        wipe_in_n = 1'b1;
        cyc(400);
        chk8("wipe bytes", 8'(USER_RAM_BYTES), 8'(wipes));
        rdchk("wipe flag", OFF_STATUS_CTRL, 8'h84);
        chk1("wipe irq", 1'b0, irq_oe_n);
        rdchk("ext ram kept", OFF_RAM_DATA, 8'ha5);
        host.wr(OFF_STATUS_CTRL, 8'h00);
        host.wr(OFF_FEATURE_EN, 8'h00);
        wipes = 0;
        wipe_in_n = 1'b0;
        cyc(300);
        wipe_in_n = 1'b1;
        chk8("no wipe", 8'h00, 8'(wipes));
        rdchk("no flag", OFF_STATUS_CTRL, 8'h80);
        $display("test wipe finished");
        end_of_test();
    end
endmodule
bind rxb_bank rxb_checker chk (.CLK, .RESETN, .AD_OE_N, .CS_N, .RD_N, .BANK_SELECT,
    .MAIN_POWER, .OTHER_IRQ, .INTERRUPT_OUT_OE_N, .USER_WIPE_WE, .USER_WIPE_ADDR);
